// [src/uart_async_receiver.sv]
/*
  Asynchronous receive path: 16x data recovery, receive shifter, two-entry
  buffer with per-entry stop-bit error, overflow and receive-pending logic.
  Assumes the serial input is synchronous to i_sys_clk and settings are
  steady plain inputs driven by software.
*/
//  Behaviour
// - oversample line 16x, shifter steps per bit
// - finished character moves into two-entry buffer
// - runs only when enabled, async, port on
// - falling edge starts character as start bit
// - half bit later check start still low
// - high start midpoint silently drops, back to hunt
// - full bit steps, majority vote, shift in
// - stop position low sets error, high clears
// - after stop push character, raise pending flag
// - data read returns oldest, removes it
// - pending while port on with unread data
// - interrupt needs all three enables set
// - error flag stored per entry, shows oldest
// - software reads error before data
// - stop error never halts nor interrupts
// - port off resets, clears error flag
// - third character while full sets overflow
// - overflow keeps buffer, blocks new characters
// - overflow cleared by receive or port disable
// - software sets pin as digital input
// - data bits assembled lsb first
// - ninth bit stored, shown for oldest entry
`include "uart_rx_map.svh"
module uart_async_receiver
  import uart_rx_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  serial_link_if.device    link,
  input  wire logic [15:0] i_baud_divisor,
  input  wire logic        i_port_enable,
  input  wire logic        i_continuous_receive_enable,
  input  wire logic        i_clocked_mode_select,
  input  wire logic        i_nine_bit_receive_enable,
  input  wire logic        i_receive_irq_enable,
  input  wire logic        i_peripheral_irq_enable,
  input  wire logic        i_global_irq_enable,
  input  wire logic        i_data_read,
  output logic [7:0]       o_receive_data,
  output logic             o_received_ninth_bit,
  output logic             o_stop_bit_error_flag,
  output logic             o_buffer_overflow_flag,
  output logic             o_receive_pending_flag,
  output logic             o_irq_request
);

  function automatic logic majority3(input logic [2:0] v);
    majority3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : majority3

  logic [15:0]  div_reg;
  logic         tick_reg;
  logic         prev_reg;
  frame_state_t state_reg;
  logic [3:0]   cnt_reg;
  logic [3:0]   bit_reg;
  logic [2:0]   vote_reg;
  logic [8:0]   shifter_reg;
  logic         nine_reg;
  logic         overflow_reg;
  rx_entry_t    mem_reg [2];
  logic         wr_ptr_reg;
  logic         rd_ptr_reg;
  logic [1:0]   count_reg;

  logic         rx_on;
  logic         line_in;
  logic         decide;
  logic         vote_bit;
  logic         stop_done;
  logic         full;
  logic         push;
  logic         pop;
  logic         avail;
  rx_entry_t    new_entry;
  rx_entry_t    head;

  // the pin is input only on this side; direction and analog select are software's
  assign line_in = link.serial_input_pin;
  assign rx_on = i_continuous_receive_enable && !i_clocked_mode_select && i_port_enable;

  // 16x tick; divisor + 1 system clocks per tick
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_reg  <= `URX_DIV_RESET;
      tick_reg <= 1'b0;
    end else if (!rx_on || div_reg == i_baud_divisor) begin
      div_reg  <= `URX_DIV_RESET;
      tick_reg <= rx_on;
    end else begin
      div_reg  <= div_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  // a tick left over from the last enabled clock must not finish a cut frame
  assign decide   = tick_reg && rx_on && (cnt_reg == `URX_VOTE_DECIDE);
  assign vote_bit = majority3({vote_reg[1:0], line_in});
  assign stop_done = decide && (state_reg == ST_STOP);
  assign full = (count_reg == `URX_FIFO_DEPTH);
  assign push = stop_done && !full;
  assign pop  = i_data_read && (count_reg != 2'h0);
  assign head = mem_reg[rd_ptr_reg];
  // port off blanks every output but overflow together, so no stale data outlives pending
  assign avail = i_port_enable && (count_reg != 2'h0);

  always_comb begin
    new_entry.stop_err = !vote_bit;
    new_entry.ninth    = nine_reg ? shifter_reg[8] : 1'b0;
    new_entry.data     = nine_reg ? shifter_reg[7:0] : shifter_reg[8:1];
  end

  // edge detector looks at tick-rate samples so a glitch between ticks is ignored
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_reg <= `URX_LINE_IDLE;
    end else if (!rx_on) begin
      prev_reg <= `URX_LINE_IDLE;
    end else if (tick_reg) begin
      prev_reg <= line_in;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
    end else if (!rx_on) begin
      state_reg <= ST_IDLE;
    end else if (tick_reg) begin
      case (state_reg)
        ST_IDLE: begin
          if (prev_reg && !line_in && !overflow_reg) state_reg <= ST_START;
        end
        ST_START: begin
          if (decide) state_reg <= vote_bit ? ST_IDLE : ST_DATA;
        end
        ST_DATA: begin
          if (decide && bit_reg == (nine_reg ? `URX_LAST_BIT_9 : `URX_LAST_BIT_8)) begin
            state_reg <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (decide) state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // counter free-runs through the frame; every centre lands on the same count
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= 4'h0;
    end else if (!rx_on || state_reg == ST_IDLE) begin
      cnt_reg <= 4'h0;
    end else if (tick_reg) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vote_reg <= 3'h7;
    end else if (tick_reg && cnt_reg >= `URX_VOTE_FIRST && cnt_reg <= `URX_VOTE_DECIDE) begin
      vote_reg <= {vote_reg[1:0], line_in};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bit_reg     <= 4'h0;
      shifter_reg <= 9'h000;
      nine_reg    <= 1'b0;
    end else if (state_reg == ST_IDLE) begin
      bit_reg  <= 4'h0;
      nine_reg <= i_nine_bit_receive_enable;
    end else if (decide && state_reg == ST_DATA) begin
      shifter_reg <= {vote_bit, shifter_reg[8:1]};
      bit_reg     <= bit_reg + 4'h1;
    end
  end

  // a stop-bit error does not touch the overflow or irq paths
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      overflow_reg <= 1'b0;
    end else if (!i_continuous_receive_enable || !i_port_enable) begin
      overflow_reg <= 1'b0;
    end else if (stop_done && full) begin
      overflow_reg <= 1'b1;
    end
  end

  for (genvar g = 0; g < 2; g++) begin : g_entry
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
        mem_reg[g] <= `URX_ENTRY_RESET;
      end else if (push && wr_ptr_reg == 1'(g)) begin
        mem_reg[g] <= new_entry;
      end
    end
  end

  // port disable flushes; receive disable leaves stored characters alone
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else if (!i_port_enable) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg  <= 2'h0;
    end else begin
      if (push) wr_ptr_reg <= !wr_ptr_reg;
      if (pop) rd_ptr_reg <= !rd_ptr_reg;
      if (push && !pop) count_reg <= count_reg + 2'h1;
      else if (pop && !push) count_reg <= count_reg - 2'h1;
    end
  end

  // outputs trail the buffer by one clock; reads need two clocks spacing
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_receive_data         <= 8'h00;
      o_received_ninth_bit   <= 1'b0;
      o_stop_bit_error_flag  <= 1'b0;
      o_buffer_overflow_flag <= 1'b0;
      o_receive_pending_flag <= 1'b0;
      o_irq_request          <= 1'b0;
    end else begin
      o_receive_data         <= avail ? head.data : 8'h00;
      o_received_ninth_bit   <= avail && head.ninth;
      o_stop_bit_error_flag  <= avail && head.stop_err;
      o_buffer_overflow_flag <= overflow_reg;
      o_receive_pending_flag <= avail;
      o_irq_request          <= avail && i_receive_irq_enable
                                && i_peripheral_irq_enable && i_global_irq_enable;
    end
  end

endmodule : uart_async_receiver

// [src/uart_rx_map.svh]
/*
  Constants for the asynchronous receive path and its remote sender:
  oversampling, vote window, frame lengths and reset values.
  Assumes inclusion by bare name from the design files only.
*/
`ifndef UART_RX_MAP_SVH
`define UART_RX_MAP_SVH

`define URX_OVERSAMPLE     5'h10
`define URX_CNT_LAST       4'hF
`define URX_VOTE_FIRST     4'h6
`define URX_VOTE_DECIDE    4'h8
`define URX_LAST_BIT_8     4'h7
`define URX_LAST_BIT_9     4'h8
`define URX_FIFO_DEPTH     2'h2
`define URX_ENTRY_RESET    10'h000
`define URX_DIV_RESET      16'h0000
`define URX_LINE_IDLE      1'b1

`endif

// [src/uart_rx_pkg.sv]
/*
  Types shared by the receiver and the remote sender.
  Assumes uart_rx_map.svh supplies the numeric constants.
*/
package uart_rx_pkg;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_START = 4'h2,
    ST_DATA  = 4'h4,
    ST_STOP  = 4'h8
  } frame_state_t;

  typedef struct packed {
    logic       stop_err;
    logic       ninth;
    logic [7:0] data;
  } rx_entry_t;

endpackage : uart_rx_pkg

// [src/serial_link_if.sv]
/*
  The serial receive line between the remote sender and the receiver.
  Assumes the sender drives the line high while idle.
*/
interface serial_link_if;
  logic serial_input_pin;
  modport device (input serial_input_pin);
  modport remote (output serial_input_pin);
endinterface : serial_link_if

// [src/serial_frame_sender.sv]
/*
  Remote asynchronous sender: start bit, 8 or 9 data bits lsb first, one stop bit.
  Assumes i_baud_divisor matches the receiver's and a single system clock.
*/
`include "uart_rx_map.svh"
module serial_frame_sender
  import uart_rx_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  serial_link_if.remote    link,
  input  wire logic [15:0] i_baud_divisor,
  input  wire logic        i_send_valid,
  input  wire logic [8:0]  i_send_data,
  input  wire logic        i_send_nine_bit,
  input  wire logic        i_send_bad_stop,
  output logic             o_send_ready
);

  logic [15:0]  div_reg;
  logic         tick_reg;
  frame_state_t state_reg;
  logic [3:0]   cnt_reg;
  logic [3:0]   bit_reg;
  logic [8:0]   shift_reg;
  logic         nine_reg;
  logic         bad_reg;
  logic         line_reg;
  logic         bit_end;

  assign bit_end = tick_reg && (cnt_reg == `URX_CNT_LAST);
  assign link.serial_input_pin = line_reg;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_reg  <= `URX_DIV_RESET;
      tick_reg <= 1'b0;
    end else if (div_reg == i_baud_divisor) begin
      div_reg  <= `URX_DIV_RESET;
      tick_reg <= 1'b1;
    end else begin
      div_reg  <= div_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 4'h0;
      bit_reg   <= 4'h0;
      shift_reg <= 9'h000;
      nine_reg  <= 1'b0;
      bad_reg   <= 1'b0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (i_send_valid) begin
            state_reg <= ST_START;
            shift_reg <= i_send_data;
            nine_reg  <= i_send_nine_bit;
            bad_reg   <= i_send_bad_stop;
            cnt_reg   <= 4'h0;
            bit_reg   <= 4'h0;
          end
        end
        ST_START: begin
          if (tick_reg) cnt_reg <= cnt_reg + 4'h1;
          if (bit_end) state_reg <= ST_DATA;
        end
        ST_DATA: begin
          if (tick_reg) cnt_reg <= cnt_reg + 4'h1;
          if (bit_end) begin
            shift_reg <= {1'b0, shift_reg[8:1]};
            bit_reg   <= bit_reg + 4'h1;
            if (bit_reg == (nine_reg ? `URX_LAST_BIT_9 : `URX_LAST_BIT_8)) state_reg <= ST_STOP;
          end
        end
        ST_STOP: begin
          if (tick_reg) cnt_reg <= cnt_reg + 4'h1;
          if (bit_end) state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      line_reg     <= `URX_LINE_IDLE;
      o_send_ready <= 1'b0;
    end else begin
      o_send_ready <= (state_reg == ST_IDLE) && !i_send_valid;
      case (state_reg)
        ST_START: line_reg <= 1'b0;
        ST_DATA:  line_reg <= shift_reg[0];
        ST_STOP:  line_reg <= !bad_reg;
        default:  line_reg <= `URX_LINE_IDLE;
      endcase
    end
  end

endmodule : serial_frame_sender

// [verif/uart_rx_monitor.sv]
/*
  Concurrent checks on the receiver outputs and the serial line.
  Assumes the bench instantiates it beside the link, signals by name.
*/
module uart_rx_monitor (
  input wire logic       i_sys_clk,
  input wire logic       i_rst_n,
  input wire logic       serial_input_pin,
  input wire logic       i_port_enable,
  input wire logic       i_continuous_receive_enable,
  input wire logic       i_receive_irq_enable,
  input wire logic       i_peripheral_irq_enable,
  input wire logic       i_global_irq_enable,
  input wire logic [7:0] o_receive_data,
  input wire logic       o_stop_bit_error_flag,
  input wire logic       o_buffer_overflow_flag,
  input wire logic       o_receive_pending_flag,
  input wire logic       o_irq_request
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  sequence s_on;
    i_port_enable && i_continuous_receive_enable;
  endsequence
  sequence s_push;
    $rose(o_receive_pending_flag);
  endsequence
  property p_irq_gate;
    o_irq_request |-> $past(i_receive_irq_enable && i_peripheral_irq_enable
                            && i_global_irq_enable);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without enables");
  // stop decided two edges before the pending flag rises
  property p_stop;
    s_push |-> o_stop_bit_error_flag == !$past(serial_input_pin, 2);
  endproperty
  a_stop: assert property (p_stop) else $error("stop error mismatch");
  property p_push_on;
    s_push |-> $past(i_port_enable, 2) && $past(i_continuous_receive_enable, 2);
  endproperty
  a_push_on: assert property (p_push_on) else $error("push while disabled");
  property p_empty_data;
    !o_receive_pending_flag |-> o_receive_data == 8'h00;
  endproperty
  a_empty_data: assert property (p_empty_data) else $error("data while empty");
  property p_err_held;
    o_stop_bit_error_flag |-> o_receive_pending_flag;
  endproperty
  a_err_held: assert property (p_err_held) else $error("error flag while empty");
  property p_port_off;
    !i_port_enable [*3] |-> !o_receive_pending_flag && !o_stop_bit_error_flag
                            && !o_buffer_overflow_flag;
  endproperty
  a_port_off: assert property (p_port_off) else $error("port off not cleared");
  property p_ovf_clear;
    !i_continuous_receive_enable [*3] |-> !o_buffer_overflow_flag;
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow kept");
  property p_ovf_sticky;
    s_on [*3] ##0 o_buffer_overflow_flag ##1 s_on [*3] |-> o_buffer_overflow_flag;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow lost");
endmodule : uart_rx_monitor

// [verif/test_uart_async_receiver.sv]
/*
  Bench: remote sender and receiver joined by the serial link.
  Assumes the src package, header, link and both ends compile first.
*/
module test_uart_async_receiver;
  timeunit 1ns;
  timeprecision 1ns;
  import uart_rx_pkg::*;
  logic        i_sys_clk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic [15:0] i_baud_divisor = 16'h0001;
  logic        i_port_enable = 1'b0;
  logic        i_continuous_receive_enable = 1'b0;
  logic        i_clocked_mode_select = 1'b0;
  logic        i_nine_bit_receive_enable = 1'b0;
  logic        i_receive_irq_enable = 1'b1;
  logic        i_peripheral_irq_enable = 1'b1;
  logic        i_global_irq_enable = 1'b1;
  logic        i_data_read = 1'b0;
  logic        i_send_valid = 1'b0;
  logic [8:0]  i_send_data = 9'h000;
  logic        i_send_bad_stop = 1'b0;
  logic        i_send_nine_bit;
  logic [7:0]  o_receive_data;
  logic        o_received_ninth_bit;
  logic        o_stop_bit_error_flag;
  logic        o_buffer_overflow_flag;
  logic        o_receive_pending_flag;
  logic        o_irq_request;
  logic        o_send_ready;
  wire logic   serial_input_pin;
  logic [7:0]  lfsr_reg = 8'h4D;
  int          errors = 0;
  int          samples_checked = 0;
  rx_entry_t   expect_q[$];
  serial_link_if link ();
  assign i_send_nine_bit = i_nine_bit_receive_enable;
  assign serial_input_pin = link.serial_input_pin;
  serial_frame_sender u_serial_frame_sender (.link(link), .*);
  uart_async_receiver u_uart_async_receiver (.link(link), .*);
  uart_rx_monitor     u_uart_rx_monitor (.*);
  always #25 i_sys_clk = ~i_sys_clk;
  function automatic logic [7:0] lfsr_step(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr_step
  task automatic cmp(input logic [9:0] got, input logic [9:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask : tick
  // bounded wait; a stuck sender ends the run as a failure
  task automatic wait_ready();
    int k;
    k = 0;
    while (o_send_ready !== 1'b1 && k < 3000) begin
      tick(1);
      k++;
    end
    if (k >= 3000) begin
      errors++;
      $display("Error at %0t: sender never ready", $time);
      final_report();
    end
  endtask : wait_ready
  task automatic send(input logic [8:0] d, input logic bad, input logic keep);
    wait_ready();
    i_send_valid <= 1'b1;
    i_send_data <= d;
    i_send_bad_stop <= bad;
    tick(1);
    i_send_valid <= 1'b0;
    tick(2);
    wait_ready();
    tick(4);
    if (keep) begin
      expect_q.push_back({bad, i_nine_bit_receive_enable & d[8], d[7:0]});
    end
  endtask : send
  // reads spaced so the outputs settle on the next entry
  task automatic pop();
    i_data_read <= 1'b1;
    tick(1);
    i_data_read <= 1'b0;
    tick(3);
  endtask : pop
  // a read consumes the oldest noted entry
  always @(posedge i_sys_clk) begin
    if (i_data_read === 1'b1 && o_receive_pending_flag === 1'b1) begin
      if (expect_q.size() == 0) cmp(10'h3FF, 10'h000);
      else cmp({o_stop_bit_error_flag, o_received_ninth_bit, o_receive_data},
               expect_q.pop_front());
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  initial begin
    tick(40000);
    errors++;
    final_report();
  end
  initial begin
    tick(3);
    i_rst_n <= 1'b1;
    i_port_enable <= 1'b1;
    i_continuous_receive_enable <= 1'b1;
    tick(2);
    lfsr_reg = lfsr_step(lfsr_reg);
    send({1'b0, lfsr_reg}, 1'b0, 1'b1);
    cmp({8'h00, o_receive_pending_flag, o_irq_request}, 10'h003);
    for (int i = 0; i < 3; i++) begin
      {i_receive_irq_enable, i_peripheral_irq_enable, i_global_irq_enable}
        <= 3'(3'b111 ^ (3'b001 << i));
      tick(3);
      cmp({8'h00, o_receive_pending_flag, o_irq_request}, 10'h002);
    end
    {i_receive_irq_enable, i_peripheral_irq_enable, i_global_irq_enable} <= 3'b111;
    pop();
    cmp({9'h000, o_receive_pending_flag}, 10'h000);
    $display("test 1 done");
    i_nine_bit_receive_enable <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      lfsr_reg = lfsr_step(lfsr_reg);
      send({lfsr_reg[0], lfsr_reg}, i == 0, i < 2);
    end
    cmp({8'h00, o_buffer_overflow_flag, o_stop_bit_error_flag}, 10'h003);
    pop();
    pop();
    send(9'h1A5, 1'b0, 1'b0);
    cmp({8'h00, o_buffer_overflow_flag, o_receive_pending_flag}, 10'h002);
    i_continuous_receive_enable <= 1'b0;
    tick(4);
    cmp({9'h000, o_buffer_overflow_flag}, 10'h000);
    i_continuous_receive_enable <= 1'b1;
    $display("test 2 done");
    i_nine_bit_receive_enable <= 1'b0;
    i_clocked_mode_select <= 1'b1;
    send(9'h03C, 1'b0, 1'b0);
    cmp({9'h000, o_receive_pending_flag}, 10'h000);
    i_clocked_mode_select <= 1'b0;
    lfsr_reg = lfsr_step(lfsr_reg);
    send({1'b0, lfsr_reg}, 1'b1, 1'b0);
    i_continuous_receive_enable <= 1'b0;
    tick(4);
    cmp({8'h00, o_stop_bit_error_flag, o_receive_pending_flag}, 10'h003);
    i_continuous_receive_enable <= 1'b1;
    i_port_enable <= 1'b0;
    tick(4);
    cmp({8'h00, o_stop_bit_error_flag, o_receive_pending_flag}, 10'h000);
    i_port_enable <= 1'b1;
    $display("test 3 done");
    final_report();
  end
endmodule : test_uart_async_receiver
